// ===== hw/flash_erase_power_mode_cmds.sv
// Summary of operation
// - Opcodes 52H/5CH erase the whole 32KB block holding the address.
// - Opcodes D8H/DCH erase the whole 64KB block holding the address.
// - Block erase runs only if select rises right after the last address bit.
// - Valid erase starts timed cycle; busy flag 1 then 0; latch cleared.
// - Block erase refused when its block lies in the protected range.
// - Opcodes 60H/C7H erase everything; select must rise after bit eight.
// - Whole-array erase only when all protect bits are zero.
// - Opcode 38H in serial mode enters quad command mode.
// - Opcode FFH in quad command mode returns to serial mode.
// - Mode switches 38H and FFH keep the write latch unchanged.
// - B9H taken when select rises after bit eight; sleep after entry delay.
// - In deep sleep only ABH and the 66H/99H pair are obeyed.
// - Sleep command during a running cycle is rejected, cycle untouched.
// - Power-up gives standby; select high alone never means deep sleep.
// - After ABH, commands accepted only once the wake delay has elapsed.
// - Wake command ignored while the busy flag is 1.
// - 4BH takes zero address, one dummy byte, shifts out 128-bit ID.
// - 24-bit addressing by default; four-byte mode uses 32-bit addresses.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module flash_erase_power_mode_cmds
  import flash_cmd_pkg::*;
#(
  parameter int unsigned   ERASE_32K_TIME_US  = 100000,
  parameter int unsigned   ERASE_64K_TIME_US  = 200000,
  parameter int unsigned   FULL_ERASE_TIME_US = 1000000,
  // Arbitrary value
  parameter logic [127:0]  UNIQUE_ID          = 128'h5A5A_1234_0F0F_C3C3_9696_7E7E_0001_8421
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        cs_n_pin,
  input  wire logic        sclk_pin,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam logic [31:0] ERASE_32K_CYC  = 32'(ERASE_32K_TIME_US * CLK_MHZ);
  localparam logic [31:0] ERASE_64K_CYC  = 32'(ERASE_64K_TIME_US * CLK_MHZ);
  localparam logic [31:0] FULL_ERASE_CYC = 32'(FULL_ERASE_TIME_US * CLK_MHZ);
  localparam logic [PWR_CNT_W-1:0] SLEEP_LOAD = PWR_CNT_W'(SLEEP_ENTRY_CYC);
  localparam logic [PWR_CNT_W-1:0] WAKE_LOAD  = PWR_CNT_W'(WAKE_CYC);
  localparam logic [PWR_CNT_W-1:0] PWR_ONE    = PWR_CNT_W'(1);
  localparam int SLEEP_HI = SLEEP_ENTRY_CYC + 1;
  localparam int WAKE_HI  = WAKE_CYC + 1;

  erase_tmr_if tmr ();

  erase_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .t       (tmr.tmr)
  );

  // Pin synchronisers: [0] first stage, [1] second, [2] edge history
  logic [2:0]  cs_sync_reg;
  logic [2:0]  sclk_sync_reg;
  logic [3:0]  io_meta_reg;
  logic [3:0]  io_sync_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_sync_reg   <= 3'h7;
      sclk_sync_reg <= 3'h0;
      io_meta_reg   <= 4'h0;
      io_sync_reg   <= 4'h0;
    end else if (ce) begin
      cs_sync_reg   <= {cs_sync_reg[1:0], cs_n_pin};
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
      io_meta_reg   <= io_in;
      io_sync_reg   <= io_meta_reg;
    end
  end

  logic cs_low;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  assign cs_low    = ~cs_sync_reg[1];
  assign cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];

  // Mode and flag state
  logic                 quad_reg;
  logic                 addr4_reg;
  logic [4:0]           prot_reg;
  logic                 write_latch_flag;
  logic                 deep_reg;
  logic                 rst_armed_reg;
  logic [PWR_CNT_W-1:0] sleep_cnt_reg;
  logic [PWR_CNT_W-1:0] wake_cnt_reg;
  logic [31:0]          erase_addr_reg;
  logic                 op_in_progress_flag;

  assign op_in_progress_flag = tmr.busy;

  // Serial receive
  logic [8:0]  bit_cnt_reg;
  logic [8:0]  bit_cnt_next;
  logic [8:0]  step;
  logic [8:0]  addr_bits;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [7:0]  opcode_reg;
  logic [31:0] addr_reg;

  assign addr_bits = addr4_reg ? ADDR4_BITS : ADDR3_BITS;

  always_comb begin
    step         = quad_reg ? QUAD_STEP : SPI_STEP;
    bit_cnt_next = (bit_cnt_reg > BIT_CNT_MAX - step) ? BIT_CNT_MAX : bit_cnt_reg + step;
    shift_next   = quad_reg ? {shift_reg[27:0], io_sync_reg} : {shift_reg[30:0], io_sync_reg[0]};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt_reg <= 9'h000;
      shift_reg   <= 32'h0;
      opcode_reg  <= 8'h00;
      addr_reg    <= 32'h0;
    end else if (ce) begin
      if (!cs_low) begin
        bit_cnt_reg <= 9'h000;
      end else if (sclk_rise) begin
        bit_cnt_reg <= bit_cnt_next;
        shift_reg   <= shift_next;
        if (bit_cnt_next == OPC_BITS) begin
          opcode_reg <= shift_next[7:0];
        end
        if (bit_cnt_next == OPC_BITS + addr_bits) begin
          addr_reg <= addr4_reg ? shift_next : {8'h00, shift_next[23:0]};
        end
      end
    end
  end

  // Frame decode at select release
  logic       len_cmd;
  logic       len_addr;
  logic       awake;
  logic       is_e32;
  logic       is_e64;
  logic       is_chip;
  logic [9:0] blk_dist;
  logic [4:0] prot_sh;
  logic       blk_prot;
  logic       erase_go;
  logic       unlock_go;
  logic       sleep_go;
  logic       wake_go;
  logic       quad_on_go;
  logic       quad_off_go;
  logic       rst_go;

  always_comb begin
    len_cmd     = bit_cnt_reg == OPC_BITS;
    len_addr    = bit_cnt_reg == OPC_BITS + addr_bits;
    awake       = !deep_reg && wake_cnt_reg == '0;
    is_e32      = opcode_reg == OP_BLOCK_ERASE_32K_A || opcode_reg == OP_BLOCK_ERASE_32K_B;
    is_e64      = opcode_reg == OP_BE64_A || opcode_reg == OP_BE64_B;
    is_chip     = opcode_reg == OP_CHIP_A || opcode_reg == OP_CHIP_B;
    // Protected range covers the top 2^(n-1) 64KB blocks
    blk_dist    = ~addr_reg[BLK64_MSB:BLK64_LSB];
    prot_sh     = prot_reg - 5'h01;
    blk_prot    = prot_reg != 5'h00 &&
                  (prot_reg >= PROT_WHOLE_MIN || {1'b0, blk_dist} < (11'h001 << prot_sh));
    erase_go    = cs_rise && awake && !op_in_progress_flag && write_latch_flag &&
                  (((is_e32 || is_e64) && len_addr && !blk_prot) ||
                   (is_chip && len_cmd && prot_reg == 5'h00));
    unlock_go   = cs_rise && awake && !op_in_progress_flag && len_cmd && opcode_reg == OP_UNLOCK;
    sleep_go    = cs_rise && awake && !op_in_progress_flag && len_cmd &&
                  opcode_reg == OP_SLEEP && sleep_cnt_reg == '0;
    wake_go     = cs_rise && deep_reg && wake_cnt_reg == '0 && !op_in_progress_flag &&
                  len_cmd && opcode_reg == OP_WAKE;
    quad_on_go  = cs_rise && awake && len_cmd && !quad_reg && opcode_reg == OP_QUAD_ON;
    quad_off_go = cs_rise && awake && len_cmd && quad_reg && opcode_reg == OP_QUAD_OFF;
    rst_go      = cs_rise && len_cmd && rst_armed_reg && !op_in_progress_flag && opcode_reg == OP_RST;
  end

  // Erase cycle launch
  always_comb begin
    tmr.start  = erase_go;
    tmr.cycles = is_chip ? FULL_ERASE_CYC : (is_e32 ? ERASE_32K_CYC : ERASE_64K_CYC);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_addr_reg <= 32'h0;
    end else if (ce && erase_go) begin
      if (is_chip) begin
        erase_addr_reg <= 32'h0;
      end else if (is_e32) begin
        erase_addr_reg <= addr_reg & MASK_32K;
      end else begin
        erase_addr_reg <= addr_reg & MASK_64K;
      end
    end
  end

  // Write latch: left alone by mode switches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_latch_flag <= 1'b0;
    end else if (ce) begin
      if (rst_go || erase_go) begin
        write_latch_flag <= 1'b0;
      end else if (unlock_go) begin
        write_latch_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quad_reg <= 1'b0;
    end else if (ce) begin
      if (rst_go || quad_off_go) begin
        quad_reg <= 1'b0;
      end else if (quad_on_go) begin
        quad_reg <= 1'b1;
      end
    end
  end

  // Reset-enable must be the frame right before reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_armed_reg <= 1'b0;
    end else if (ce && cs_rise) begin
      rst_armed_reg <= len_cmd && opcode_reg == OP_RST_EN;
    end
  end

  // Deep sleep entry and wake delays; power-up is standby
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_cnt_reg <= '0;
      wake_cnt_reg  <= '0;
      deep_reg      <= 1'b0;
    end else if (ce) begin
      if (rst_go) begin
        sleep_cnt_reg <= '0;
        wake_cnt_reg  <= '0;
        deep_reg      <= 1'b0;
      end else begin
        if (sleep_go) begin
          sleep_cnt_reg <= SLEEP_LOAD;
        end else if (sleep_cnt_reg != '0) begin
          sleep_cnt_reg <= sleep_cnt_reg - PWR_ONE;
        end
        if (wake_go) begin
          wake_cnt_reg <= WAKE_LOAD;
        end else if (wake_cnt_reg != '0) begin
          wake_cnt_reg <= wake_cnt_reg - PWR_ONE;
        end
        if (sleep_cnt_reg == PWR_ONE) begin
          deep_reg <= 1'b1;
        end else if (wake_cnt_reg == PWR_ONE) begin
          deep_reg <= 1'b0;
        end
      end
    end
  end

  // Unique ID shift-out on falling serial clock
  logic [127:0] uid_sh_reg;
  logic         read_phase;
  logic         addr_zero;

  assign read_phase = opcode_reg == OP_UID && awake && !op_in_progress_flag &&
                      bit_cnt_reg >= OPC_BITS + addr_bits + DUMMY_BITS;
  assign addr_zero  = addr4_reg ? shift_next == 32'h0 : shift_next[23:0] == 24'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uid_sh_reg <= 128'h0;
      io_out     <= 4'h0;
      io_oe      <= 4'h0;
    end else if (ce) begin
      if (!cs_low) begin
        io_out <= 4'h0;
        io_oe  <= 4'h0;
      end else if (sclk_rise && bit_cnt_next == OPC_BITS + addr_bits) begin
        uid_sh_reg <= addr_zero ? UNIQUE_ID : 128'h0;
      end else if (sclk_fall && read_phase) begin
        if (quad_reg) begin
          io_oe      <= OE_QUAD;
          io_out     <= uid_sh_reg[127:124];
          uid_sh_reg <= {uid_sh_reg[123:0], 4'h0};
        end else begin
          io_oe      <= OE_SPI;
          io_out     <= {2'b00, uid_sh_reg[127], 1'b0};
          uid_sh_reg <= {uid_sh_reg[126:0], 1'b0};
        end
      end
    end
  end

  // AXI4-Lite write channel
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_go;

  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg == CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prot_reg  <= PROT_RST;
      addr4_reg <= ADDR4_RST;
    end else if (ce && wr_go && aw_addr_reg == CTRL_OFS) begin
      if (w_strb_reg[0]) begin
        prot_reg <= w_data_reg[CTRL_PROT_MSB:CTRL_PROT_LSB];
      end
      if (w_strb_reg[1]) begin
        addr4_reg <= w_data_reg[CTRL_ADDR4_BIT];
      end
    end
  end

  // AXI4-Lite read channel
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr[7:0])
      CTRL_OFS: begin
        rd_word[CTRL_PROT_MSB:CTRL_PROT_LSB] = prot_reg;
        rd_word[CTRL_ADDR4_BIT]             = addr4_reg;
      end
      STATUS_OFS: begin
        rd_word[ST_BUSY_BIT]   = op_in_progress_flag;
        rd_word[ST_LATCH_BIT]  = write_latch_flag;
        rd_word[ST_QUAD_BIT]   = quad_reg;
        rd_word[ST_DEEP_BIT]   = deep_reg;
        rd_word[ST_WAKE_BIT]   = wake_cnt_reg != '0;
        rd_word[ST_SLPEND_BIT] = sleep_cnt_reg != '0;
      end
      ERASE_ADDR_OFS: rd_word = erase_addr_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_erase_needs_latch: assert property ($rose(op_in_progress_flag) |-> $past(write_latch_flag))
    else $error("erase started without write latch");
  a_erase_at_frame_end: assert property ($rose(op_in_progress_flag) |-> $past(cs_rise))
    else $error("erase started away from select rise");
  a_latch_cleared: assert property ($rose(op_in_progress_flag) |-> !write_latch_flag)
    else $error("write latch still set in erase cycle");
  a_block32_base: assert property (ce && erase_go && is_e32 |=> erase_addr_reg[14:0] == 15'h0 && op_in_progress_flag)
    else $error("32KB erase base not aligned");
  a_block64_base: assert property (ce && erase_go && is_e64 |=> erase_addr_reg[15:0] == 16'h0)
    else $error("64KB erase base not aligned");
  a_block_protect: assert property (cs_rise && blk_prot && !op_in_progress_flag && (is_e32 || is_e64)
    |=> !op_in_progress_flag)
    else $error("protected block was erased");
  a_chip_protect: assert property (cs_rise && is_chip && prot_reg != 5'h00 && !op_in_progress_flag
    |=> !op_in_progress_flag)
    else $error("chip erase ran with protection set");
  a_sleep_entry: assert property (ce && sleep_go |=> !deep_reg ##[1:SLEEP_HI] deep_reg)
    else $error("deep sleep not entered after entry delay");
  a_sleep_busy_reject: assert property (op_in_progress_flag && cs_rise && opcode_reg == OP_SLEEP
    |=> sleep_cnt_reg == '0)
    else $error("sleep taken during erase cycle");
  a_deep_ignores: assert property (deep_reg && cs_rise && opcode_reg != OP_WAKE && opcode_reg != OP_RST
    |=> $stable(write_latch_flag) && $stable(quad_reg) && !$rose(op_in_progress_flag))
    else $error("command obeyed in deep sleep");
  a_wake_delay: assert property (ce && wake_go |=> deep_reg ##[1:WAKE_HI] !deep_reg)
    else $error("wake delay not honoured");
  a_wake_busy_ignore: assert property (op_in_progress_flag && cs_rise && opcode_reg == OP_WAKE
    |=> wake_cnt_reg == '0)
    else $error("wake accepted during busy cycle");
  a_quad_keeps_latch: assert property (ce && (quad_on_go || quad_off_go) |=> $stable(write_latch_flag))
    else $error("mode switch disturbed write latch");

  c_block_erase: cover property ($rose(op_in_progress_flag) && erase_addr_reg != 32'h0);
  c_sleep_wake: cover property ($fell(deep_reg));
  c_uid_out: cover property ($rose(io_oe[1]));
  c_quad_on: cover property ($rose(quad_reg));
endmodule : flash_erase_power_mode_cmds

// ===== include/flash_cmd_pkg.sv
package flash_cmd_pkg;
  localparam int unsigned CLK_MHZ        = 10;
  localparam int unsigned NS_PER_US      = 1000;
  // Serial opcodes
  localparam logic [7:0]  OP_BLOCK_ERASE_32K_A      = 8'h52;
  localparam logic [7:0]  OP_BLOCK_ERASE_32K_B      = 8'h5C;
  localparam logic [7:0]  OP_BE64_A      = 8'hD8;
  localparam logic [7:0]  OP_BE64_B      = 8'hDC;
  localparam logic [7:0]  OP_CHIP_A      = 8'h60;
  localparam logic [7:0]  OP_CHIP_B      = 8'hC7;
  localparam logic [7:0]  OP_QUAD_ON     = 8'h38;
  localparam logic [7:0]  OP_QUAD_OFF    = 8'hFF;
  localparam logic [7:0]  OP_SLEEP       = 8'hB9;
  localparam logic [7:0]  OP_WAKE        = 8'hAB;
  localparam logic [7:0]  OP_RST_EN      = 8'h66;
  localparam logic [7:0]  OP_RST         = 8'h99;
  localparam logic [7:0]  OP_UID         = 8'h4B;
  localparam logic [7:0]  OP_UNLOCK      = 8'h06;
  // Frame lengths in bits
  localparam logic [8:0]  OPC_BITS       = 9'h008;
  localparam logic [8:0]  ADDR3_BITS     = 9'h018;
  localparam logic [8:0]  ADDR4_BITS     = 9'h020;
  localparam logic [8:0]  DUMMY_BITS     = 9'h008;
  localparam logic [8:0]  BIT_CNT_MAX    = 9'h1FF;
  localparam logic [8:0]  SPI_STEP       = 9'h001;
  localparam logic [8:0]  QUAD_STEP      = 9'h004;
  // Power-state delays
  localparam int unsigned SLEEP_ENTRY_NS = 3000;
  localparam int unsigned SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int unsigned WAKE_NS        = 3000;
  localparam int unsigned WAKE_CYC       = (WAKE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int unsigned PWR_CNT_W      = 16;
  // Block geometry and protection
  localparam logic [31:0] MASK_32K       = 32'hFFFF_8000;
  localparam logic [31:0] MASK_64K       = 32'hFFFF_0000;
  localparam int unsigned BLK64_LSB      = 16;
  localparam int unsigned BLK64_MSB      = 25;
  localparam logic [4:0]  PROT_WHOLE_MIN = 5'h0B;
  // Register map
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  STATUS_OFS     = 8'h04;
  localparam logic [7:0]  ERASE_ADDR_OFS = 8'h08;
  localparam int unsigned CTRL_PROT_LSB  = 0;
  localparam int unsigned CTRL_PROT_MSB  = 4;
  localparam int unsigned CTRL_ADDR4_BIT = 8;
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_LATCH_BIT   = 1;
  localparam int unsigned ST_QUAD_BIT    = 2;
  localparam int unsigned ST_DEEP_BIT    = 3;
  localparam int unsigned ST_WAKE_BIT    = 4;
  localparam int unsigned ST_SLPEND_BIT  = 5;
  localparam logic [4:0]  PROT_RST       = 5'h00;
  localparam logic        ADDR4_RST      = 1'b0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [3:0]  OE_SPI         = 4'h2;
  localparam logic [3:0]  OE_QUAD        = 4'hF;
endpackage : flash_cmd_pkg

// ===== include/erase_tmr_if.sv
`timescale 1ns/100ps
interface erase_tmr_if;
  logic        start;
  logic [31:0] cycles;
  logic        busy;
  modport ctl (output start, output cycles, input busy);
  modport tmr (input start, input cycles, output busy);
endinterface : erase_tmr_if

// ===== hw/erase_timer.sv
`timescale 1ns/100ps
module erase_timer
  import flash_cmd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  erase_tmr_if.tmr t
);
  logic [31:0] cnt_reg;
  logic        busy_reg;

  // Self-timed cycle: busy for exactly the loaded number of cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg  <= 32'h0;
      busy_reg <= 1'b0;
    end else if (ce) begin
      if (t.start) begin
        cnt_reg  <= t.cycles;
        busy_reg <= 1'b1;
      end else if (cnt_reg != 32'h0) begin
        cnt_reg  <= cnt_reg - 32'h1;
        busy_reg <= (cnt_reg != 32'h1);
      end
    end
  end

  assign t.busy = busy_reg;

  a_timer_start: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && t.start |=> busy_reg && cnt_reg == $past(t.cycles))
    else $error("timer did not load on start");
endmodule : erase_timer

// ===== verif/spi_host.sv
`timescale 1ns/100ps
module spi_host (
  input  wire logic       aclk,
  input  wire logic       miso,
  output logic            cs_n,
  output logic            sclk,
  output logic      [3:0] io,
  output logic      [7:0] rx
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io   = 4'h0;
    rx   = 8'h00;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge aclk);
  endtask : gap
  // Select held low for the whole frame, MSB first, nibbles in quad mode
  task automatic frame(input logic [63:0] d, input int n, input logic q);
    cs_n <= 1'b0;
    for (int i = n; i > 0; i -= (q ? 4 : 1)) begin
      io <= q ? d[i-1 -: 4] : {~io[3:1], d[i-1]};
      gap(4);
      sclk <= 1'b1;
      rx   <= {rx[6:0], miso};
      gap(4);
      sclk <= 1'b0;
    end
    gap(1);
    cs_n <= 1'b1;
    io   <= ~io;
    gap(6);
  endtask : frame
endmodule : spi_host

// ===== verif/tb.sv
`timescale 1ns/100ps
module tb;
  import flash_cmd_pkg::*;
  // Arbitrary value
  localparam logic [127:0] ID = 128'hC3A5_0000_0000_0000_0000_0000_0000_0001;
  logic        aclk, aresetn, ce, aw_v, w_v, b_r, ar_v, r_r, awready, wready, bvalid, arready, rvalid;
  logic [3:0]  io_out, io_oe, pin, strb;
  logic [31:0] awaddr, wdata, araddr, rdata, got;
  logic [1:0]  bresp, rresp, resp;
  int          err_total, tests_run, cyc;
  logic [7:0]  ops [6] = '{OP_BLOCK_ERASE_32K_A, OP_BLOCK_ERASE_32K_B, OP_BE64_A, OP_BE64_B, OP_CHIP_A, OP_CHIP_B};
  logic [31:0] bases [6] = '{32'h0012_8000, 32'h0012_8000, 32'h0012_0000, 32'h0012_0000,
                             32'h0000_0000, 32'h0000_0000};
  wire  [3:0]  hio;
  wire  [7:0]  rx;
  wire         cs_n, sclk;
  assign pin = (io_oe & io_out) | (~io_oe & hio);
  spi_host h (.aclk(aclk), .miso(io_out[1]), .cs_n(cs_n), .sclk(sclk), .io(hio), .rx(rx));
  flash_erase_power_mode_cmds #(.ERASE_32K_TIME_US(2), .ERASE_64K_TIME_US(20), .FULL_ERASE_TIME_US(2),
    .UNIQUE_ID(ID)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .cs_n_pin(cs_n), .sclk_pin(sclk),
    .io_in(pin), .io_out(io_out), .io_oe(io_oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(aw_v),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(w_v),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(b_r),
    .s_axi_araddr(araddr), .s_axi_arvalid(ar_v), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(r_r));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= {24'h00_0000, a};
    wdata  <= d;
    aw_v   <= 1'b1;
    w_v    <= 1'b1;
    b_r    <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) aw_v <= 1'b0;
      if (wready === 1'b1) w_v <= 1'b0;
    end while (bvalid !== 1'b1);
    b_r <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= {24'h00_0000, a};
    ar_v   <= 1'b1;
    r_r    <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) ar_v <= 1'b0;
    end while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    r_r <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(got, e);
  endtask : rdc
  task automatic idle;
    rd(STATUS_OFS);
    for (int k = 0; k < 300 && got[ST_BUSY_BIT] !== 1'b0; k++) rd(STATUS_OFS);
  endtask : idle
  initial begin
    for (cyc = 0; cyc < 20000; cyc++) @(posedge aclk);
    err_total++;
    test_done;
  end
  initial begin
    {aresetn, aw_v, w_v, b_r, ar_v, r_r} = 6'h00;
    {awaddr, wdata, araddr} = 96'h0;
    {ce, strb} = 5'h1F;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    h.gap(4);
    rdc(CTRL_OFS, 32'h0000_0000);
    rdc(STATUS_OFS, 32'h0000_0000);
    rd(8'h0C);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      h.frame({56'h0, OP_UNLOCK}, 8, 1'b0);
      if (i < 4) h.frame({32'h0, ops[i], 24'h12_D456}, 32, 1'b0);
      else h.frame({56'h0, ops[i]}, 8, 1'b0);
      rdc(STATUS_OFS, 32'h0000_0001);
      rdc(ERASE_ADDR_OFS, bases[i]);
      idle;
      chk(got, 32'h0000_0000);
    end
    $display("test erase done");
    h.frame({56'h0, OP_UNLOCK}, 8, 1'b0);
    h.frame({40'h0, OP_BLOCK_ERASE_32K_A, 16'h1234}, 24, 1'b0);
    rdc(STATUS_OFS, 32'h0000_0002);
    h.frame({56'h0, OP_QUAD_ON}, 8, 1'b0);
    rdc(STATUS_OFS, 32'h0000_0006);
    h.frame({56'h0, OP_QUAD_OFF}, 8, 1'b1);
    rdc(STATUS_OFS, 32'h0000_0002);
    // Frame sent while frozen must be lost
    ce <= 1'b0;
    h.frame({56'h0, OP_QUAD_ON}, 8, 1'b0);
    ce <= 1'b1;
    rdc(STATUS_OFS, 32'h0000_0002);
    $display("test quad done");
    strb <= 4'h2;
    wr(CTRL_OFS, 32'h0000_011F);
    rdc(CTRL_OFS, 32'h0000_0100);
    strb <= 4'hF;
    wr(CTRL_OFS, 32'h0000_0101);
    h.frame({24'h0, OP_BE64_A, 32'h03FF_0000}, 40, 1'b0);
    rdc(STATUS_OFS, 32'h0000_0002);
    h.frame({56'h0, OP_CHIP_A}, 8, 1'b0);
    rdc(STATUS_OFS, 32'h0000_0002);
    h.frame({24'h0, OP_BE64_B, 32'h0100_0000}, 40, 1'b0);
    rdc(ERASE_ADDR_OFS, 32'h0100_0000);
    h.frame({56'h0, OP_SLEEP}, 8, 1'b0);
    h.frame({56'h0, OP_WAKE}, 8, 1'b0);
    rdc(STATUS_OFS, 32'h0000_0001);
    idle;
    wr(CTRL_OFS, 32'h0000_0000);
    $display("test protect done");
    h.frame({56'h0, OP_SLEEP}, 8, 1'b0);
    h.gap(40);
    rdc(STATUS_OFS, 32'h0000_0008);
    h.frame({56'h0, OP_UNLOCK}, 8, 1'b0);
    rdc(STATUS_OFS, 32'h0000_0008);
    h.frame({56'h0, OP_WAKE}, 8, 1'b0);
    h.gap(40);
    rdc(STATUS_OFS, 32'h0000_0000);
    h.frame({56'h0, OP_SLEEP}, 8, 1'b0);
    h.gap(40);
    h.frame({56'h0, OP_RST_EN}, 8, 1'b0);
    h.frame({56'h0, OP_RST}, 8, 1'b0);
    rdc(STATUS_OFS, 32'h0000_0000);
    $display("test sleep done");
    h.frame({16'h0, OP_UID, 40'h0}, 48, 1'b0);
    chk({24'h0, rx}, {24'h0, ID[127:120]});
    $display("test id done");
    test_done;
  end
endmodule : tb
